// ==== ssi_blink.sv ====
// Fixed-period divider: one-cycle tick and a square-wave phase.
// Assumes the single system clock; restart_i realigns the period.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_consts.svh"

module ssi_blink #(
   parameter int HALF_CYC = 5000000
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic restart_i,
   output var  logic tick_o,
   output var  logic phase_o
);

   logic [`SSI_CNT_W-1:0] cnt;
   logic [`SSI_CNT_W-1:0] next_cnt;
   logic                  next_tick;
   logic                  next_phase;

   always_comb begin
      next_cnt   = cnt + `SSI_CNT_W'(1);
      next_tick  = 1'b0;
      next_phase = phase_o;
      if (restart_i) begin
         next_cnt   = '0;
      end else if (cnt == `SSI_CNT_W'(HALF_CYC - 1)) begin
         next_cnt   = '0;
         next_tick  = 1'b1;
         next_phase = ~phase_o;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt     <= '0;
         tick_o  <= 1'b0;
         phase_o <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         tick_o  <= next_tick;
         phase_o <= next_phase;
      end
   end

endmodule
`default_nettype wire

// ==== ssi_consts.svh ====
// Constants for the servo status indicator block.
// Assumes a 10 MHz system clock and a byte-addressed Avalon-MM slave.
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define SSI_CLK_HZ       10000000
`define SSI_MS_PER_S     1000
`define SSI_BLINK_MS     500
`define SSI_DWELL_MS     1000
`define SSI_CNT_W        24

// ****************************************
// Register map and fields
// ****************************************
`define SSI_ADDR_W       4
`define SSI_REG_CTRL     4'h0
`define SSI_REG_CFG      4'h4
`define SSI_REG_EFF      4'h8
`define SSI_REG_STAT     4'hC
`define SSI_CTRL_SRST    0
`define SSI_CFG_W        2
`define SSI_CFG_TEST     0
`define SSI_CFG_BASIC    1
`define SSI_CFG_RST      2'h0
`define SSI_CFG_PAD      30
`define SSI_STAT_PAD     22
`define SSI_RDATA_RST    32'h0000_0000

// ****************************************
// Network management machine encoding
// ****************************************
`define SSI_NMT_INIT     2'h0
`define SSI_NMT_PREOP    2'h1
`define SSI_NMT_SAFEOP   2'h2
`define SSI_NMT_OPER     2'h3

// ****************************************
// Display codes; 5'h00..5'h0F show a hex digit
// ****************************************
`define SSI_DISP_BOOT    5'h10
`define SSI_DISP_NOCONN  5'h11
`define SSI_DISP_NOLINK  5'h12
`define SSI_DISP_PREOP   5'h13
`define SSI_DISP_SAFEOP  5'h14
`define SSI_DISP_OPER    5'h15
`define SSI_DISP_STOP    5'h16
`define SSI_DISP_TEST    5'h17
`define SSI_DISP_CPUERR  5'h18
`define SSI_DISP_UPDATE  5'h19
`define SSI_DISP_INIT    5'h1A
`define SSI_DISP_IPSET   5'h1B
`define SSI_SYNC_W       28
`define SSI_ALM_W        12

`endif

// ==== ssi_panel_model.sv ====
// Panel model: the servo and error LEDs and the one-digit display seen from outside.
// Assumes the indicator's registered outputs and the bench clock.
`timescale 1ns/1ps
`default_nettype none

module ssi_panel_model (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       clear_i,
   input  wire logic       servo_led_i,
   input  wire logic       err_led_i,
   input  wire logic [4:0] disp_code_i,
   output var  logic [7:0] servo_toggles_o,
   output var  logic [7:0] err_toggles_o,
   output var  logic [7:0] code_changes_o
);
   logic       servo_q;
   logic       err_q;
   logic [4:0] code_q;

   // An eye sees changes, so edges are counted rather than levels
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         servo_q         <= 1'b0;
         err_q           <= 1'b0;
         code_q          <= 5'h10;
         servo_toggles_o <= 8'h00;
         err_toggles_o   <= 8'h00;
         code_changes_o  <= 8'h00;
      end else begin
         servo_q <= servo_led_i;
         err_q   <= err_led_i;
         code_q  <= disp_code_i;
         if (clear_i) begin
            servo_toggles_o <= 8'h00;
            err_toggles_o   <= 8'h00;
            code_changes_o  <= 8'h00;
         end else begin
            servo_toggles_o <= servo_toggles_o + {7'h00, servo_q ^ servo_led_i};
            err_toggles_o   <= err_toggles_o + {7'h00, err_q ^ err_led_i};
            code_changes_o  <= code_changes_o + {7'h00, code_q != disp_code_i};
         end
      end
   end
endmodule
`default_nettype wire

// ==== ssi_pkg.sv ====
// Types shared by the servo status indicator block.
// Uses nothing from ssi_consts.svh; the state encodings are literal values here.
package ssi_pkg;

   // Display sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_BOOT = 5'h01,
      ST_NET  = 5'h02,
      ST_ALM2 = 5'h04,
      ST_ALM1 = 5'h08,
      ST_ALM0 = 5'h10
   } ssi_disp_st_t;

endpackage

// ==== ssi_top.sv ====
// Servo status indicator: status LEDs and one-digit display sequencer.
// Assumes status flags arrive unsynchronised and an Avalon-MM master.
//
// Notes on behaviour
// [R1] Servo LED: off, blink ready, on servo-on
// [R2] Error LED: off, blink warning, on alarm
// [R3] Run LED on unless an alarm is active
// [R4] Each port link LED follows its link
// [R5] Startup sequence, then network status after check
// [R6] Alarm number follows network status when flagged
// [R7] Distinct code while controller not connected
// [R8] Distinct pre-operational and safe-operational codes
// [R9] Stopped code when configured as reserved station
// [R10] Codes for test, firmware update, initialization
// [R11] Code for processor watchdog error
// [R12] Code while IP address is being set
// [R13] Restart parameters apply only after reset
// [R14] Blink from fixed equal on/off divider
// [R15] Special codes chosen by fixed priority
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_consts.svh"

module ssi_top #(
   parameter int BLINK_CYC = `SSI_CLK_HZ / `SSI_MS_PER_S * `SSI_BLINK_MS,
   parameter int DWELL_CYC = `SSI_CLK_HZ / `SSI_MS_PER_S * `SSI_DWELL_MS
) (
   input  wire logic                   clk_i,
   input  wire logic                   nrst_i,
   input  wire logic [`SSI_ADDR_W-1:0] avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output var  logic [31:0]            avs_readdata_o,
   output var  logic                   avs_waitrequest_o,
   input  wire logic                   ready_i,
   input  wire logic                   servo_on_i,
   input  wire logic                   alarm_i,
   input  wire logic                   warning_i,
   input  wire logic                   port_a_link_i,
   input  wire logic                   port_b_link_i,
   input  wire logic                   check_done_i,
   input  wire logic                   ctrl_conn_i,
   input  wire logic                   data_link_i,
   input  wire logic                   reserved_i,
   input  wire logic [1:0]             nmt_state_i,
   input  wire logic                   fw_update_i,
   input  wire logic                   param_init_i,
   input  wire logic                   ip_setting_i,
   input  wire logic                   cpu_err_i,
   input  wire logic [`SSI_ALM_W-1:0]  alarm_num_i,
   output var  logic                   servo_on_indicator_o,
   output var  logic                   err_led_o,
   output var  logic                   run_led_o,
   output var  logic                   port_a_link_indicator_o,
   output var  logic                   port_b_link_indicator_o,
   output var  logic [4:0]             disp_code_o
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Alarm number bits are synchronised one by one; it is held steady
   // while an alarm stands, so a torn word lasts at most one cycle.
   logic [`SSI_SYNC_W-1:0] sync1;
   logic [`SSI_SYNC_W-1:0] sync2;
   logic                   s_ready, s_servo_on, s_alarm, s_warning;
   logic                   s_link_a, s_link_b, s_check_done, s_ctrl_conn;
   logic                   s_data_link, s_reserved, s_fw_update, s_param_init;
   logic                   s_ip_setting, s_cpu_err;
   logic [1:0]             s_nmt;
   logic [`SSI_ALM_W-1:0]  s_alarm_num;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {ready_i, servo_on_i, alarm_i, warning_i, port_a_link_i,
                   port_b_link_i, check_done_i, ctrl_conn_i, data_link_i,
                   reserved_i, fw_update_i, param_init_i, ip_setting_i,
                   cpu_err_i, nmt_state_i, alarm_num_i};
         sync2 <= sync1;
      end
   end

   assign {s_ready, s_servo_on, s_alarm, s_warning, s_link_a, s_link_b,
           s_check_done, s_ctrl_conn, s_data_link, s_reserved, s_fw_update,
           s_param_init, s_ip_setting, s_cpu_err, s_nmt, s_alarm_num} = sync2;

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // Every access gets exactly one wait cycle, then completes.
   logic [`SSI_CFG_W-1:0] cfg_pend, next_cfg_pend;
   logic [`SSI_CFG_W-1:0] cfg_eff, next_cfg_eff;
   logic                  srst, next_srst;
   logic [31:0]           next_rdata;
   logic                  next_wait;
   logic                  acc;
   ssi_pkg::ssi_disp_st_t state, next_state;

   assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

   always_comb begin
      next_wait     = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      next_cfg_pend = cfg_pend;
      next_cfg_eff  = cfg_eff;
      next_srst     = 1'b0;
      next_rdata    = avs_readdata_o;
      if (avs_read_i && avs_waitrequest_o) begin
         unique case (avs_address_i)
            `SSI_REG_CFG:  next_rdata = {`SSI_CFG_PAD'(0), cfg_pend};
            `SSI_REG_EFF:  next_rdata = {`SSI_CFG_PAD'(0), cfg_eff};
            `SSI_REG_STAT: next_rdata = {`SSI_STAT_PAD'(0), state, disp_code_o};
            default:       next_rdata = `SSI_RDATA_RST;
         endcase
      end
      if (acc && avs_write_i && avs_byteenable_i[0]) begin
         if (avs_address_i == `SSI_REG_CFG) begin
            // New value is staged only; cfg_eff is untouched
            next_cfg_pend = avs_writedata_i[`SSI_CFG_W-1:0]; // R13
         end
         if (avs_address_i == `SSI_REG_CTRL) begin
            next_srst = avs_writedata_i[`SSI_CTRL_SRST];
         end
      end
      if (srst) begin
         next_cfg_eff = cfg_pend; // R13
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= `SSI_RDATA_RST;
         cfg_pend          <= `SSI_CFG_RST;
         cfg_eff           <= `SSI_CFG_RST;
         srst              <= 1'b0;
      end else begin
         avs_waitrequest_o <= next_wait;
         avs_readdata_o    <= next_rdata;
         cfg_pend          <= next_cfg_pend;
         cfg_eff           <= next_cfg_eff;
         srst              <= next_srst;
      end
   end

   // ****************************************
   // Dividers
   // ****************************************
   logic blink_tick, blink_phase, dwell_tick;

   ssi_blink #(.HALF_CYC(BLINK_CYC)) u_blink (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .restart_i (1'b0),
      .tick_o    (blink_tick),
      .phase_o   (blink_phase)
   ); // R14

   ssi_blink #(.HALF_CYC(DWELL_CYC)) u_dwell (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .restart_i (state != next_state),
      .tick_o    (dwell_tick),
      .phase_o   ()
   );

   // ****************************************
   // Display sequencer
   // ****************************************
   function automatic logic [4:0] net_code(input logic [`SSI_CFG_W-1:0] cfg,
                                           input logic cpu, upd, ini, ips,
                                           input logic conn, link, rsv,
                                           input logic [1:0] network_management_machine);
      logic [4:0] c;
      c = `SSI_DISP_OPER;
      if (cpu) c = `SSI_DISP_CPUERR; // R11 R15
      else if (upd) c = `SSI_DISP_UPDATE; // R10 R15
      else if (ini) c = `SSI_DISP_INIT; // R10 R15
      else if (ips) c = `SSI_DISP_IPSET; // R12 R15
      else if (cfg[`SSI_CFG_TEST]) c = `SSI_DISP_TEST; // R10 R15
      else if (!conn) c = `SSI_DISP_NOCONN; // R7
      else if (cfg[`SSI_CFG_BASIC]) c = `SSI_DISP_OPER;
      else if (!link) c = `SSI_DISP_NOLINK;
      else if (rsv) c = `SSI_DISP_STOP; // R9
      else if (network_management_machine == `SSI_NMT_PREOP) c = `SSI_DISP_PREOP; // R8
      else if (network_management_machine == `SSI_NMT_SAFEOP) c = `SSI_DISP_SAFEOP; // R8
      else if (network_management_machine == `SSI_NMT_INIT) c = `SSI_DISP_NOLINK;
      return c;
   endfunction

   logic [4:0] net_now, next_disp;
   logic       next_servo, next_err, next_run;

   assign net_now = net_code(cfg_eff, s_cpu_err, s_fw_update, s_param_init,
                             s_ip_setting, s_ctrl_conn, s_data_link,
                             s_reserved, s_nmt);

   always_comb begin
      next_state = state;
      unique case (state)
         ssi_pkg::ST_BOOT: if (s_check_done) next_state = ssi_pkg::ST_NET; // R5
         ssi_pkg::ST_NET: begin
            if (dwell_tick && (s_alarm || s_warning)) begin
               next_state = ssi_pkg::ST_ALM2; // R6
            end
         end
         ssi_pkg::ST_ALM2: if (dwell_tick) next_state = ssi_pkg::ST_ALM1;
         ssi_pkg::ST_ALM1: if (dwell_tick) next_state = ssi_pkg::ST_ALM0;
         ssi_pkg::ST_ALM0: if (dwell_tick) next_state = ssi_pkg::ST_NET;
         default: next_state = ssi_pkg::ST_BOOT;
      endcase
      // Software reset restarts the whole sequence
      if (srst) next_state = ssi_pkg::ST_BOOT; // R5
      unique case (next_state)
         ssi_pkg::ST_ALM2: next_disp = {1'b0, s_alarm_num[11:8]}; // R6
         ssi_pkg::ST_ALM1: next_disp = {1'b0, s_alarm_num[7:4]};
         ssi_pkg::ST_ALM0: next_disp = {1'b0, s_alarm_num[3:0]};
         ssi_pkg::ST_NET:  next_disp = net_now; // R5
         default:          next_disp = `SSI_DISP_BOOT;
      endcase
      next_servo = s_ready && (s_servo_on || blink_phase); // R1
      next_err   = s_alarm || (s_warning && blink_phase); // R2
      next_run   = !s_alarm; // R3
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state                   <= ssi_pkg::ST_BOOT;
         disp_code_o             <= `SSI_DISP_BOOT;
         servo_on_indicator_o    <= 1'b0;
         err_led_o               <= 1'b0;
         run_led_o               <= 1'b0;
         port_a_link_indicator_o <= 1'b0;
         port_b_link_indicator_o <= 1'b0;
      end else begin
         state                   <= next_state;
         disp_code_o             <= next_disp;
         servo_on_indicator_o    <= next_servo;
         err_led_o               <= next_err;
         run_led_o               <= next_run;
         port_a_link_indicator_o <= s_link_a; // R4
         port_b_link_indicator_o <= s_link_b; // R4
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   logic specials;
   assign specials = s_cpu_err | s_fw_update | s_param_init | s_ip_setting
                     | cfg_eff[`SSI_CFG_TEST];

   a_servo_led_dark: assert property (!s_ready |=> !servo_on_indicator_o) // R1
      else $error("servo LED lit while not ready");
   a_servo_led_on: assert property (s_ready && s_servo_on |=> servo_on_indicator_o) // R1
      else $error("servo LED dark while servo on");
   a_err_led_alarm: assert property (s_alarm |=> err_led_o) // R2
      else $error("error LED dark during alarm");
   a_err_led_idle: assert property (!s_alarm && !s_warning |=> !err_led_o) // R2
      else $error("error LED lit with no alarm or warning");
   a_run_led_alarm: assert property (s_alarm |=> !run_led_o) // R3
      else $error("run LED lit during alarm");
   a_run_led_ok: assert property (!s_alarm |=> run_led_o) // R3
      else $error("run LED dark without alarm");
   a_link_follow: assert property (##1 port_a_link_indicator_o == $past(s_link_a)
                                   && port_b_link_indicator_o == $past(s_link_b)) // R4
      else $error("link LED does not follow link");
   a_boot_hold: assert property (state == ssi_pkg::ST_BOOT && !s_check_done && !srst
                                 |=> disp_code_o == `SSI_DISP_BOOT) // R5
      else $error("display left startup before check done");
   a_alarm_next: assert property (state == ssi_pkg::ST_NET && dwell_tick && s_alarm && !srst
                                  |=> state == ssi_pkg::ST_ALM2) // R6
      else $error("alarm number not shown after network status");
   a_noconn_code: assert property (next_state == ssi_pkg::ST_NET && !specials && !s_ctrl_conn
                                   |=> disp_code_o == `SSI_DISP_NOCONN) // R7
      else $error("not-connected code missing");
   a_cpu_first: assert property (next_state == ssi_pkg::ST_NET && s_cpu_err
                                 |=> disp_code_o == `SSI_DISP_CPUERR) // R11
      else $error("processor error not given first place");
   a_eff_hold: assert property (!srst |=> $stable(cfg_eff)) // R13
      else $error("effective parameters changed without reset");
   a_blink_flip: assert property (blink_tick |-> blink_phase != $past(blink_phase)) // R14
      else $error("blink phase did not toggle on tick");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
                                  |=> !avs_waitrequest_o) // bus handshake, this design's own decision
      else $error("bus access not answered in one wait cycle");

   c_alarm_seq: cover property (state == ssi_pkg::ST_ALM0 && dwell_tick);
   c_servo_blink: cover property (s_ready && !s_servo_on && blink_tick);
   c_soft_reset: cover property (srst && state != ssi_pkg::ST_BOOT);
   c_cpu_err: cover property (disp_code_o == `SSI_DISP_CPUERR);

endmodule
`default_nettype wire

// ==== ssi_top_fix_note_unused.sv ====
`timescale 1ns/1ps

// ==== tb_servo_status_indicator_logic.sv ====
// Self-checking bench for the servo status indicator.
// Assumes ssi_top with short blink and dwell counts, and the panel model.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_consts.svh"

module tb_servo_status_indicator_logic;
   localparam int BLINK = 8;
   localparam int DWELL = 20;
   logic        clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [3:0]  avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic        ready_i, servo_on_i, alarm_i, warning_i, port_a_link_i, port_b_link_i;
   logic        check_done_i, ctrl_conn_i, data_link_i, reserved_i;
   logic        fw_update_i, param_init_i, ip_setting_i, cpu_err_i, clear;
   logic [1:0]  nmt_state_i;
   logic [11:0] alarm_num_i;
   logic        servo_on_indicator_o, err_led_o, run_led_o;
   logic        port_a_link_indicator_o, port_b_link_indicator_o;
   logic [4:0]  disp_code_o;
   logic [7:0]  servo_tg, err_tg, code_ch;
   logic [9:0]  net_tab [7] = '{10'h171, 10'h272, 10'h333, 10'h354, 10'h375, 10'h3F6, 10'h312};
   logic [31:0] r;
   int          n_errors, check_count, cycles = 0;

   ssi_top #(.BLINK_CYC(BLINK), .DWELL_CYC(DWELL)) uut (.clk_i, .nrst_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .ready_i, .servo_on_i, .alarm_i, .warning_i, .port_a_link_i,
      .port_b_link_i, .check_done_i, .ctrl_conn_i, .data_link_i, .reserved_i, .nmt_state_i,
      .fw_update_i, .param_init_i, .ip_setting_i, .cpu_err_i, .alarm_num_i,
      .servo_on_indicator_o, .err_led_o, .run_led_o, .port_a_link_indicator_o,
      .port_b_link_indicator_o, .disp_code_o);

   ssi_panel_model panel (.clk_i, .nrst_i, .clear_i(clear), .servo_led_i(servo_on_indicator_o),
      .err_led_i(err_led_o), .disp_code_i(disp_code_o), .servo_toggles_o(servo_tg),
      .err_toggles_o(err_tg), .code_changes_o(code_ch));

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic fail(input string m);
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk_bit(input logic exp, input logic got, input string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk_code(input logic [4:0] exp, input string m);
      check_count++;
      if (disp_code_o !== exp) fail(m);
   endtask
   task automatic chk_word(input logic [31:0] exp, input logic [31:0] got, input string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      @(posedge clk_i);
      avs_address_i    <= a;
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      avs_write_i      <= wr;
      avs_read_i       <= !wr;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20) fail("bus answer missing");
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask
   task automatic soft_reset();
      bus(1'b1, `SSI_REG_CTRL, 32'h0000_0001, 4'hF);
      tick(8);
   endtask
   // Steady lamps never change; a blinking one toggles 2 or 3 times in 20 cycles
   function automatic logic led_ok(input logic on, blink, lvl, input logic [7:0] tg);
      return blink ? (tg >= 8'h02 && tg <= 8'h03) : (lvl === on && tg == 8'h00);
   endfunction
   function automatic logic [4:0] exp_special(input int i);
      return (i < 4) ? 5'h18 + 5'(i) : `SSI_DISP_OPER;
   endfunction

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail("run timed out");
         complete_run();
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst_i = 1'b0;
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
      {ready_i, servo_on_i, alarm_i, warning_i, port_a_link_i, port_b_link_i} = '0;
      {check_done_i, ctrl_conn_i, data_link_i, reserved_i, nmt_state_i} = '0;
      {fw_update_i, param_init_i, ip_setting_i, cpu_err_i, alarm_num_i, clear} = '0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(51428));
      tick(2);
      nrst_i <= 1'b1;
      tick(30);
      chk_code(`SSI_DISP_BOOT, "boot code");
      chk_bit(1'b1, code_ch == 8'h00, "display moved before check");
      check_done_i <= 1'b1;
      tick(6);
      chk_code(`SSI_DISP_NOCONN, "no controller code");
      $display("test boot done");

      for (int i = 0; i < 7; i++) begin
         {ctrl_conn_i, data_link_i, reserved_i, nmt_state_i} <= net_tab[i][9:5];
         tick(6);
         chk_code(net_tab[i][4:0], "network code");
      end
      reserved_i <= 1'b0;
      // Last table entry leaves the state machine in init; return to operational
      nmt_state_i <= `SSI_NMT_OPER;
      for (int i = 0; i < 5; i++) begin
         {cpu_err_i, fw_update_i, param_init_i, ip_setting_i} <= 4'hF >> i;
         tick(6);
         chk_code(exp_special(i), "special priority");
      end
      $display("test display codes done");

      bus(1'b0, `SSI_REG_CFG, 32'h0, 4'hF);
      chk_word(32'h0, rd, "config reset value");
      bus(1'b1, `SSI_REG_CFG, 32'h0000_0003, 4'h0);
      bus(1'b0, `SSI_REG_CFG, 32'h0, 4'hF);
      chk_word(32'h0, rd, "lane-off write took effect");
      bus(1'b1, 4'h2, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 4'h2, 32'h0, 4'hF);
      chk_word(32'h0, rd, "unmapped read");
      bus(1'b1, `SSI_REG_CFG, 32'h0000_0001, 4'hF);
      bus(1'b0, `SSI_REG_CTRL, 32'h0, 4'hF);
      chk_word(32'h0, rd, "control read");
      bus(1'b0, `SSI_REG_EFF, 32'h0, 4'hF);
      chk_word(32'h0, rd, "effective before reset");
      chk_code(`SSI_DISP_OPER, "test mode too early");
      soft_reset();
      bus(1'b0, `SSI_REG_EFF, 32'h0, 4'hF);
      chk_word(32'h1, rd, "effective after reset");
      chk_code(`SSI_DISP_TEST, "test mode code");
      bus(1'b0, `SSI_REG_STAT, 32'h0, 4'hF);
      chk_word({22'h0, 5'h02, `SSI_DISP_TEST}, rd, "status word");
      bus(1'b1, `SSI_REG_CFG, 32'h0000_0002, 4'hF);
      soft_reset();
      data_link_i <= 1'b0;
      tick(6);
      chk_code(`SSI_DISP_OPER, "basic network code");
      data_link_i <= 1'b1;
      bus(1'b1, `SSI_REG_CFG, 32'h0, 4'hF);
      soft_reset();
      $display("test registers done");

      for (int i = 0; i < 16; i++) begin
         r = (i == 0) ? 32'h1F : (i == 1) ? 32'h11 : $urandom;
         {port_b_link_i, port_a_link_i, warning_i} <= r[6:4];
         alarm_i    <= r[2] & r[3];
         servo_on_i <= r[0] & r[1];
         ready_i    <= r[0];
         tick(5);
         clear <= 1'b1;
         tick(1);
         clear <= 1'b0;
         tick(2 * BLINK + 4);
         chk_bit(1'b1, led_ok(r[0] & r[1], r[0] & !r[1], servo_on_indicator_o, servo_tg),
                 "servo lamp");
         chk_bit(1'b1, led_ok(r[2] & r[3], r[4] & !(r[2] & r[3]), err_led_o, err_tg),
                 "error lamp");
         chk_bit(!(r[2] & r[3]), run_led_o, "run lamp");
         chk_bit(r[5], port_a_link_indicator_o, "port a link lamp");
         chk_bit(r[6], port_b_link_indicator_o, "port b link lamp");
      end
      $display("test lamps done");

      {alarm_i, warning_i} <= 2'b00;
      // An alarm sequence begun in the lamp test takes three dwells plus sync delay
      tick(4 * DWELL);
      alarm_num_i <= 12'($urandom);
      alarm_i <= 1'b1;
      for (int n = 0; n < 3 * DWELL && disp_code_o === `SSI_DISP_OPER; n++)
         @(posedge clk_i);
      tick(DWELL / 2);
      for (int d = 2; d >= 0; d--) begin
         chk_code({1'b0, alarm_num_i[4 * d +: 4]}, "alarm digit");
         tick(DWELL);
      end
      chk_code(`SSI_DISP_OPER, "back to network code");
      alarm_i <= 1'b0;
      $display("test alarm digits done");
      complete_run();
   end
endmodule
`default_nettype wire
